// ---- core/pg_delay_timer.sv ----
/*
 One power-good delay counter: counts ticks while its condition holds.
 Assumes i_run and i_tick come from logic on the same clock.
*/
`timescale 1ns/100ps
module pg_delay_timer #(
   parameter int W = 16
) (
   input wire logic i_clk_sys,
   input wire logic i_srst,
   input wire logic i_run,
   input wire logic i_tick,
   input wire logic [W-1:0] i_target,
   output logic o_done
);
   logic [W-1:0] count_reg;
   logic [W-1:0] count_next;

   always_comb begin
      count_next = count_reg;
      if (!i_run) begin
         count_next = '0;
      end else if (i_tick && count_reg < i_target) begin
         count_next = count_reg + 1'b1;
      end
   end

   always_ff @(posedge i_clk_sys) begin
      if (i_srst) begin
         count_reg <= '0;
         o_done <= 1'b0;
      end else begin
         count_reg <= count_next;
         o_done <= i_run && (count_next >= i_target);
      end
   end
endmodule : pg_delay_timer

// ---- core/pgsync_config_bank.sv ----
/*
 Power-good delay and mask, sync pin setup and phase stack configuration,
 written and read through decoded command strobes.
 Assumes the command decoder, fault logic and PWM tick share i_clk_sys,
 and that the sync pin is asynchronous.
*/
`timescale 1ns/100ps
`include "pgsync_defines.svh"

// How it works
// - Fall delay code 15:12: code 0 gives 1 PWM clock, else 2^N+1.
// - Rise delay code 11:8: code 0 gives 1 PWM clock, else 2^N+1.
// - Each set mask bit keeps its event source from pulling power good low.
// - Power good held low when disabled, during turn-on, ramps and fault shutdown.
// - Fall ramp and fault shutdown pull power good low with no delay.
// - Unmasked fault pulls low unless its response says keep running.
// - Separate rise and fall counters; short events leave power good high.
// - Power-good and stack registers writable only while conversion is disabled.
// - Sync direction 7:6: off, drive out, take in, auto-detect.
// - Sync edge bit 5 picks falling edge at 0, rising edge at 1.
// - Unsupported sync or stack data is refused and flagged as invalid.
// - Auto mode samples pin at enable: high or fast toggling picks input.
// - Follower always takes sync in; flags fault if sync absent or lost.
// - In-to-out change at low limit keeps frequency there until re-enable.
// - In-to-out change while held off by sync fault runs oscillator at 70%.
// - Stack bits 15:8 read zero; first back-channel address fixed at zero.
// - Stack stop code 0 to 3 selects one to four phases; others invalid.
// - Standalone at power-up keeps back-channel off until next power-up.
// - Multi-phase power-up accepts live stack changes from 0 to 3.
module pgsync_config_bank #(
   parameter int NOM_PERIOD = `SYNC_NOM_PERIOD_CYC,
   parameter int DW = `PG_DELAY_W
) (
   input wire logic i_clk_sys,
   input wire logic i_srst,
   input wire pgsync_pkg::cmd_req_t i_cmd,
   output logic [15:0] o_rd_data,
   output logic o_rd_valid,
   output logic o_invalid_cmd,
   output logic o_invalid_data,
   input wire logic [15:0] i_nvm_pg_cfg,
   input wire logic [7:0] i_nvm_sync_cfg,
   input wire logic [3:0] i_nvm_stack_stop,
   input wire pgsync_pkg::conv_phase_t i_phase,
   input wire logic [7:0] i_events,
   input wire logic [7:0] i_keep_running,
   input wire logic i_pwm_tick,
   input wire logic i_follower,
   input wire logic i_at_in_low_limit,
   input wire logic i_sync_pin,
   input wire logic i_sync_fault_clr,
   output logic o_power_good_out,
   output logic o_sync_out_en,
   output logic o_sync_in_en,
   output logic o_sync_rising_sel,
   output logic o_osc_lock,
   output logic o_sync_fault,
   output logic o_freq_floor_70,
   output logic o_backchan_en,
   output logic [3:0] o_backchan_last_addr
);

   ////////////////////////////////////////////////////////////////////////
   // Declarations

   logic boot_done_reg;
   logic [15:0] pg_cfg_reg;
   logic [2:0] sync_cfg_reg;
   logic [3:0] stack_stop_reg;
   logic en_q_reg;
   logic auto_in_reg;
   logic tog_q_reg;
   logic eff_in_q_reg;
   logic en_rise;
   logic wr_pg;
   logic wr_sync;
   logic wr_stack;
   logic bad_code;
   logic sync_bad;
   logic stack_bad;
   logic locked;
   logic pin_level;
   logic pin_rise;
   logic pin_fall;
   logic pin_toggling;
   logic ev_active;
   logic forced_low;
   logic bypass_fall;
   logic fall_done;
   logic rise_done;
   logic eff_in;
   logic eff_out;
   logic fault_set;
   logic [DW-1:0] fall_target;
   logic [DW-1:0] rise_target;
   pgsync_pkg::sync_dir_t dir;

   function automatic logic [DW-1:0] delay_cycles(input logic [3:0] code);
      logic [DW-1:0] one;
      one = DW'(1);
      if (code == 4'h0) begin
         delay_cycles = one;
      end else begin
         delay_cycles = (one << code) + one;
      end
   endfunction : delay_cycles

   ////////////////////////////////////////////////////////////////////////
   // Command decode

   assign en_rise = i_phase.enabled && !en_q_reg;
   // Conversion enabled turns both registers read-only
   assign locked = i_phase.enabled;
   assign sync_bad = i_cmd.wdata[15:8] != 8'h00
      || i_cmd.wdata[`SYNC_FIXED_MSB:0] != `SYNC_FIXED_VAL;
   assign stack_bad = i_cmd.wdata[15:4] != 12'h000
      || i_cmd.wdata[`STACK_STOP_MSB:0] > `STACK_STOP_MAX;
   assign wr_pg = i_cmd.wr && i_cmd.code == `CMD_POWER_GOOD_CONFIG && !locked;
   assign wr_sync = i_cmd.wr && i_cmd.code == `CMD_CLOCK_SYNC_SETUP && !sync_bad;
   assign wr_stack = i_cmd.wr && i_cmd.code == `CMD_PHASE_STACK_SETUP
      && !locked && !stack_bad;
   assign bad_code = i_cmd.code != `CMD_POWER_GOOD_CONFIG
      && i_cmd.code != `CMD_CLOCK_SYNC_SETUP
      && i_cmd.code != `CMD_PHASE_STACK_SETUP;

   always_ff @(posedge i_clk_sys) begin
      if (i_srst) begin
         o_invalid_cmd <= 1'b0;
         o_invalid_data <= 1'b0;
      end else begin
         o_invalid_cmd <= (i_cmd.wr || i_cmd.rd) && bad_code
            || i_cmd.wr && locked && (i_cmd.code == `CMD_POWER_GOOD_CONFIG
            || i_cmd.code == `CMD_PHASE_STACK_SETUP);
         o_invalid_data <= i_cmd.wr && (i_cmd.code == `CMD_CLOCK_SYNC_SETUP && sync_bad
            || i_cmd.code == `CMD_PHASE_STACK_SETUP && !locked && stack_bad);
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Register storage, loaded from non-volatile values one cycle after reset

   always_ff @(posedge i_clk_sys) begin
      if (i_srst) begin
         boot_done_reg <= 1'b0;
         pg_cfg_reg <= `RST_PG_CFG;
         sync_cfg_reg <= 3'(`RST_SYNC_CFG >> `SYNC_EDGE_BIT);
         stack_stop_reg <= `RST_STACK_STOP;
         o_backchan_en <= 1'b0;
      end else if (!boot_done_reg) begin
         boot_done_reg <= 1'b1;
         pg_cfg_reg <= i_nvm_pg_cfg;
         sync_cfg_reg <= i_nvm_sync_cfg[`SYNC_DIR_MSB:`SYNC_EDGE_BIT];
         stack_stop_reg <= (i_nvm_stack_stop > `STACK_STOP_MAX) ?
            `RST_STACK_STOP : i_nvm_stack_stop;
         // Back-channel state is decided once, at power-up only
         o_backchan_en <= (i_nvm_stack_stop != 4'h0)
            && (i_nvm_stack_stop <= `STACK_STOP_MAX);
      end else begin
         if (wr_pg) begin
            pg_cfg_reg <= i_cmd.wdata;
         end
         if (wr_sync) begin
            sync_cfg_reg <= i_cmd.wdata[`SYNC_DIR_MSB:`SYNC_EDGE_BIT];
         end
         if (wr_stack) begin
            stack_stop_reg <= i_cmd.wdata[`STACK_STOP_MSB:0];
         end
      end
   end

   always_ff @(posedge i_clk_sys) begin
      if (i_srst) begin
         o_backchan_last_addr <= `RST_STACK_STOP;
      end else begin
         // A standalone boot leaves the last address idle until power-up
         o_backchan_last_addr <= o_backchan_en ? stack_stop_reg : 4'h0;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Read path

   always_ff @(posedge i_clk_sys) begin
      if (i_srst) begin
         o_rd_data <= 16'h0000;
         o_rd_valid <= 1'b0;
      end else begin
         o_rd_valid <= i_cmd.rd && !bad_code;
         if (i_cmd.rd) begin
            case (i_cmd.code)
               `CMD_POWER_GOOD_CONFIG: begin
                  o_rd_data <= pg_cfg_reg;
               end
               `CMD_CLOCK_SYNC_SETUP: begin
                  o_rd_data <= {8'h00, sync_cfg_reg, `SYNC_FIXED_VAL};
               end
               `CMD_PHASE_STACK_SETUP: begin
                  o_rd_data <= {8'h00, `STACK_FIRST_ADDR, stack_stop_reg};
               end
               default: begin
                  o_rd_data <= 16'h0000;
               end
            endcase
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Power good

   assign ev_active = |(i_events & ~pg_cfg_reg[`PG_MASK_MSB:0] & ~i_keep_running);
   assign forced_low = !i_phase.enabled || i_phase.ton_delay || i_phase.ton_rise
      || i_phase.toff_fall || i_phase.fault_shut;
   assign bypass_fall = i_phase.toff_fall || i_phase.fault_shut;
   assign fall_target = delay_cycles(pg_cfg_reg[`PG_FALL_MSB:`PG_FALL_LSB]);
   assign rise_target = delay_cycles(pg_cfg_reg[`PG_RISE_MSB:`PG_RISE_LSB]);

   // Each counter runs only while its own condition holds, so a short event
   // never reaches the fall count and the high level is kept
   pg_delay_timer #(
      .W(DW)
   ) u_fall_timer (
      .i_clk_sys(i_clk_sys),
      .i_srst(i_srst),
      .i_run(ev_active && !forced_low),
      .i_tick(i_pwm_tick),
      .i_target(fall_target),
      .o_done(fall_done)
   );

   pg_delay_timer #(
      .W(DW)
   ) u_rise_timer (
      .i_clk_sys(i_clk_sys),
      .i_srst(i_srst),
      .i_run(!ev_active && !forced_low),
      .i_tick(i_pwm_tick),
      .i_target(rise_target),
      .o_done(rise_done)
   );

   always_ff @(posedge i_clk_sys) begin
      if (i_srst) begin
         o_power_good_out <= 1'b0;
      end else if (forced_low || bypass_fall) begin
         o_power_good_out <= 1'b0;
      end else if (fall_done) begin
         o_power_good_out <= 1'b0;
      end else if (rise_done) begin
         o_power_good_out <= 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Sync pin

   sync_pin_monitor #(
      .NOM_PERIOD(NOM_PERIOD)
   ) u_sync_mon (
      .i_clk_sys(i_clk_sys),
      .i_srst(i_srst),
      .i_pin(i_sync_pin),
      .o_level(pin_level),
      .o_rise(pin_rise),
      .o_fall(pin_fall),
      .o_toggling(pin_toggling)
   );

   assign dir = pgsync_pkg::sync_dir_t'(sync_cfg_reg[2:1]);

   always_ff @(posedge i_clk_sys) begin
      if (i_srst) begin
         en_q_reg <= 1'b0;
         tog_q_reg <= 1'b0;
         auto_in_reg <= 1'b0;
      end else begin
         en_q_reg <= i_phase.enabled;
         tog_q_reg <= pin_toggling;
         if (en_rise) begin
            auto_in_reg <= pin_level || pin_toggling;
         end
      end
   end

   always_comb begin
      eff_in = 1'b0;
      eff_out = 1'b0;
      if (i_follower) begin
         eff_in = 1'b1;
      end else begin
         case (dir)
            pgsync_pkg::SYNC_OFF: begin
               eff_in = 1'b0;
            end
            pgsync_pkg::SYNC_OUT: begin
               eff_out = 1'b1;
            end
            pgsync_pkg::SYNC_IN: begin
               eff_in = 1'b1;
            end
            pgsync_pkg::SYNC_AUTO: begin
               eff_in = auto_in_reg;
               eff_out = !auto_in_reg;
            end
            default: begin
               eff_in = 1'b0;
            end
         endcase
      end
   end

   always_ff @(posedge i_clk_sys) begin
      if (i_srst) begin
         o_sync_in_en <= 1'b0;
         o_sync_out_en <= 1'b0;
         o_sync_rising_sel <= 1'b0;
         o_osc_lock <= 1'b0;
      end else begin
         o_sync_in_en <= eff_in;
         o_sync_out_en <= eff_out;
         o_sync_rising_sel <= sync_cfg_reg[0];
         o_osc_lock <= eff_in && (sync_cfg_reg[0] ? pin_rise : pin_fall);
      end
   end

   // Set beats clear when both land in one cycle
   assign fault_set = i_follower && (en_rise && !pin_toggling
      || i_phase.enabled && en_q_reg && tog_q_reg && !pin_toggling);

   always_ff @(posedge i_clk_sys) begin
      if (i_srst) begin
         o_sync_fault <= 1'b0;
      end else if (fault_set) begin
         o_sync_fault <= 1'b1;
      end else if (i_sync_fault_clr) begin
         o_sync_fault <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Frequency floor after an in-to-out change while running

   always_ff @(posedge i_clk_sys) begin
      if (i_srst) begin
         eff_in_q_reg <= 1'b0;
         o_freq_floor_70 <= 1'b0;
      end else begin
         eff_in_q_reg <= eff_in;
         if (en_rise) begin
            o_freq_floor_70 <= 1'b0;
         end else if (i_phase.enabled && eff_in_q_reg && eff_out
            && (i_at_in_low_limit || o_sync_fault)) begin
            o_freq_floor_70 <= 1'b1;
         end
      end
   end

endmodule : pgsync_config_bank

// ---- core/pgsync_defines.svh ----
/*
 Command codes, field positions, reset values and timing counts of the
 power-good, sync and stack configuration bank.
 Assumes it is included by bare name wherever these macros are used.
*/
`ifndef PGSYNC_DEFINES_SVH
`define PGSYNC_DEFINES_SVH

`define CMD_POWER_GOOD_CONFIG 8'he3
`define CMD_CLOCK_SYNC_SETUP 8'he4
`define CMD_PHASE_STACK_SETUP 8'hec

`define PG_FALL_MSB 15
`define PG_FALL_LSB 12
`define PG_RISE_MSB 11
`define PG_RISE_LSB 8
`define PG_MASK_MSB 7

`define SYNC_DIR_MSB 7
`define SYNC_DIR_LSB 6
`define SYNC_EDGE_BIT 5
`define SYNC_FIXED_MSB 4
`define SYNC_FIXED_VAL 5'h10

`define STACK_STOP_MSB 3
`define STACK_STOP_MAX 4'h3
`define STACK_FIRST_ADDR 4'h0

`define RST_PG_CFG 16'h0000
`define RST_SYNC_CFG 8'h10
`define RST_STACK_STOP 4'h0

`define SYNC_NOM_PERIOD_CYC 8
`define PG_DELAY_W 16

`endif

// ---- core/pgsync_pkg.sv ----
/*
 Types shared by the configuration bank and its helpers.
 Assumes nothing beyond a SystemVerilog compiler.
*/
package pgsync_pkg;

   typedef enum logic [1:0] {
      SYNC_OFF  = 2'b00,
      SYNC_OUT  = 2'b01,
      SYNC_IN   = 2'b10,
      SYNC_AUTO = 2'b11
   } sync_dir_t;

   typedef struct packed {
      logic wr;
      logic rd;
      logic [7:0] code;
      logic [15:0] wdata;
   } cmd_req_t;

   typedef struct packed {
      logic enabled;
      logic ton_delay;
      logic ton_rise;
      logic toff_fall;
      logic fault_shut;
   } conv_phase_t;

endpackage : pgsync_pkg

// ---- core/sync_pin_monitor.sv ----
/*
 Synchroniser, edge finder and rate check for the sync pin.
 Assumes the pin is asynchronous to i_clk_sys and slower than half its rate.
*/
`timescale 1ns/100ps
module sync_pin_monitor #(
   parameter int NOM_PERIOD = 8
) (
   input wire logic i_clk_sys,
   input wire logic i_srst,
   input wire logic i_pin,
   output logic o_level,
   output logic o_rise,
   output logic o_fall,
   output logic o_toggling
);
   // Faster than 75 % of nominal rate means period under 4/3 of nominal
   localparam int FAST_LIM = (NOM_PERIOD * 4) / 3;
   localparam int LOSS_LIM = 2 * FAST_LIM;
   localparam logic [15:0] FAST_CYC = 16'(FAST_LIM);
   localparam logic [15:0] LOSS_CYC = 16'(LOSS_LIM);

   logic meta_reg;
   logic sync_reg;
   logic prev_reg;
   logic [15:0] gap_reg;

   always_ff @(posedge i_clk_sys) begin
      if (i_srst) begin
         meta_reg <= 1'b0;
         sync_reg <= 1'b0;
         prev_reg <= 1'b0;
      end else begin
         meta_reg <= i_pin;
         sync_reg <= meta_reg;
         prev_reg <= sync_reg;
      end
   end

   assign o_level = sync_reg;
   assign o_rise = sync_reg && !prev_reg;
   assign o_fall = !sync_reg && prev_reg;

   // Saturating gap counter; a late edge or a long gap drops the toggling flag
   always_ff @(posedge i_clk_sys) begin
      if (i_srst) begin
         gap_reg <= 16'h0000;
         o_toggling <= 1'b0;
      end else if (o_rise) begin
         gap_reg <= 16'h0001;
         o_toggling <= (gap_reg < FAST_CYC);
      end else begin
         if (gap_reg != 16'hffff) begin
            gap_reg <= gap_reg + 16'h0001;
         end
         if (gap_reg >= LOSS_CYC) begin
            o_toggling <= 1'b0;
         end
      end
   end
endmodule : sync_pin_monitor

// ---- verification/pgsync_config_bank_chk.sv ----
/*
 Concurrent checks on the config bank: answers, refusals, power-good forcing.
 Assumes it is bound to the top module and sees only its ports.
*/
`timescale 1ns/100ps
`include "pgsync_defines.svh"
module pgsync_config_bank_chk #(
   parameter int NOM_PERIOD = 8,
   parameter int DW = 16
) (
   input wire logic i_clk_sys,
   input wire logic i_srst,
   input wire pgsync_pkg::cmd_req_t i_cmd,
   input wire logic [15:0] o_rd_data,
   input wire logic o_rd_valid,
   input wire logic o_invalid_cmd,
   input wire logic o_invalid_data,
   input wire pgsync_pkg::conv_phase_t i_phase,
   input wire logic i_follower,
   input wire logic o_power_good_out,
   input wire logic o_sync_out_en,
   input wire logic o_sync_in_en,
   input wire logic o_backchan_en,
   input wire logic [3:0] o_backchan_last_addr
);
   logic boot_reg;
   default clocking cb @(posedge i_clk_sys);
   endclocking
   default disable iff (i_srst);
   // Writes in the boot cycle are dropped and reads see reset values, so they must arm nothing
   always_ff @(posedge i_clk_sys) begin
      boot_reg <= i_srst;
   end
   ////////////////////////////////////////////////////////////////////////////
   sequence s_locked_wr;
      i_cmd.wr && !boot_reg && i_phase.enabled &&
      (i_cmd.code == `CMD_POWER_GOOD_CONFIG || i_cmd.code == `CMD_PHASE_STACK_SETUP);
   endsequence
   sequence s_bad_sync;
      i_cmd.wr && !boot_reg && i_cmd.code == `CMD_CLOCK_SYNC_SETUP &&
      (i_cmd.wdata[15:8] != 8'h00 || i_cmd.wdata[4:0] != 5'h10);
   endsequence
   sequence s_bad_stack;
      i_cmd.wr && !boot_reg && !i_phase.enabled && i_cmd.code == `CMD_PHASE_STACK_SETUP &&
      (i_cmd.wdata[15:4] != 12'h000 || i_cmd.wdata[3:0] > 4'h3);
   endsequence
   ////////////////////////////////////////////////////////////////////////////
   a_locked_write: assert property (s_locked_wr |=> o_invalid_cmd)
      else $error("locked register write not refused");
   a_bad_sync: assert property (s_bad_sync |=> o_invalid_data)
      else $error("bad sync data not flagged");
   a_bad_stack: assert property (s_bad_stack |=> o_invalid_data)
      else $error("bad stack data not flagged");
   a_stack_readback: assert property (
      i_cmd.rd && !boot_reg && i_cmd.code == `CMD_PHASE_STACK_SETUP
      |=> o_rd_valid && o_rd_data[15:4] == 12'h000)
      else $error("stack read upper bits not zero");
   a_sync_fixed: assert property (
      i_cmd.rd && !boot_reg && i_cmd.code == `CMD_CLOCK_SYNC_SETUP
      |=> o_rd_valid && o_rd_data[15:8] == 8'h00 && o_rd_data[4:0] == 5'h10)
      else $error("sync read fixed bits wrong");
   // Bits 3:0 hold the four forcing phases, the top bit is the enable
   a_forced_low: assert property (
      (!i_phase.enabled || (|i_phase[3:0])) |=> !o_power_good_out)
      else $error("power good high while forced low");
   a_fall_bypass: assert property (
      $rose(i_phase.toff_fall || i_phase.fault_shut) |=> !o_power_good_out [*2])
      else $error("fall ramp did not drop power good at once");
   a_dir_exclusive: assert property (!(o_sync_out_en && o_sync_in_en))
      else $error("sync in and out both enabled");
   a_standalone_addr: assert property (
      !o_backchan_en |-> o_backchan_last_addr == 4'h0)
      else $error("back-channel address without back-channel");
   a_addr_range: assert property (o_backchan_last_addr <= 4'h3)
      else $error("back-channel address out of range");
   a_follower_input: assert property (
      (!boot_reg && i_follower) [*3] |=> o_sync_in_en)
      else $error("follower not taking sync in");
endmodule : pgsync_config_bank_chk

bind pgsync_config_bank pgsync_config_bank_chk #(.NOM_PERIOD(NOM_PERIOD), .DW(DW)) chk_i (
   .i_clk_sys(i_clk_sys), .i_srst(i_srst), .i_cmd(i_cmd), .o_rd_data(o_rd_data),
   .o_rd_valid(o_rd_valid), .o_invalid_cmd(o_invalid_cmd), .o_invalid_data(o_invalid_data),
   .i_phase(i_phase), .i_follower(i_follower), .o_power_good_out(o_power_good_out),
   .o_sync_out_en(o_sync_out_en), .o_sync_in_en(o_sync_in_en),
   .o_backchan_en(o_backchan_en), .o_backchan_last_addr(o_backchan_last_addr)
);

// ---- verification/sync_source.sv ----
/*
 External sync source facing the sync pin: 160 ns period while running.
 Assumes the bank samples the pin asynchronously.
*/
`timescale 1ns/100ps
module sync_source (
   input wire logic i_run,
   output logic o_pin
);
   // Stands low when stopped so auto-detect sees a quiet pin
   initial begin
      o_pin = 1'b0;
      #7;
      forever begin
         #80;
         o_pin = i_run ? ~o_pin : 1'b0;
      end
   end
endmodule : sync_source

// ---- verification/tb_pgsync_config_bank.sv ----
/*
 Self-checking bench for the config bank: register rows, power good, sync, stack.
 Assumes the design files and the checker are compiled first.
*/
`timescale 1ns/100ps
`include "pgsync_defines.svh"
module tb_pgsync_config_bank;
   typedef struct {logic [7:0] code; logic [15:0] wd; logic [15:0] rd; logic ic; logic id;} row_t;
   logic clk_sys = 1'b0, srst = 1'b1, rd_valid, invalid_cmd, invalid_data, power_good_out;
   logic [15:0] rd_data, rdat_s;
   logic ic_s, id_s, rv_s, sync_pin, sync_out_en, sync_in_en, sync_rising_sel, osc_lock;
   logic sync_fault, freq_floor_70, backchan_en, run = 1'b0, follower = 1'b0;
   logic at_in_low_limit = 1'b0, sync_fault_clr = 1'b0, pwm_tick = 1'b1;
   logic [3:0] backchan_last_addr, nvm_stack_stop = 4'h0;
   logic [7:0] events = 8'h00, keep_running = 8'h00;
   pgsync_pkg::cmd_req_t cmd = '0;
   pgsync_pkg::conv_phase_t phase = '0;
   int fail_count = 0, compares = 0, cycles = 0, locks;
   row_t rows[13] = '{
      '{8'he3, 16'h31a5, 16'h31a5, 1'b0, 1'b0}, '{8'he4, 16'h0010, 16'h0010, 1'b0, 1'b0},
      '{8'he4, 16'h0050, 16'h0050, 1'b0, 1'b0}, '{8'he4, 16'h00f0, 16'h00f0, 1'b0, 1'b0},
      '{8'he4, 16'h00b0, 16'h00b0, 1'b0, 1'b0}, '{8'he4, 16'h00b1, 16'h00b0, 1'b0, 1'b1},
      '{8'he4, 16'h01b0, 16'h00b0, 1'b0, 1'b1}, '{8'hec, 16'h0003, 16'h0003, 1'b0, 1'b0},
      '{8'hec, 16'h0004, 16'h0003, 1'b0, 1'b1}, '{8'hec, 16'h0013, 16'h0003, 1'b0, 1'b1},
      '{8'hec, 16'h0000, 16'h0000, 1'b0, 1'b0}, '{8'h55, 16'h0000, 16'h0000, 1'b1, 1'b0},
      '{8'hec, 16'h0003, 16'h0003, 1'b0, 1'b0}};
   always #10 clk_sys = ~clk_sys;
   sync_source partner (.i_run(run), .o_pin(sync_pin));
   pgsync_config_bank dut (
      .i_clk_sys(clk_sys), .i_srst(srst), .i_cmd(cmd), .o_rd_data(rd_data),
      .o_rd_valid(rd_valid), .o_invalid_cmd(invalid_cmd), .o_invalid_data(invalid_data),
      .i_nvm_pg_cfg(16'h10ff), .i_nvm_sync_cfg(8'h90), .i_nvm_stack_stop(nvm_stack_stop),
      .i_phase(phase), .i_events(events), .i_keep_running(keep_running), .i_pwm_tick(pwm_tick),
      .i_follower(follower), .i_at_in_low_limit(at_in_low_limit), .i_sync_pin(sync_pin),
      .i_sync_fault_clr(sync_fault_clr), .o_power_good_out(power_good_out),
      .o_sync_out_en(sync_out_en), .o_sync_in_en(sync_in_en),
      .o_sync_rising_sel(sync_rising_sel), .o_osc_lock(osc_lock), .o_sync_fault(sync_fault),
      .o_freq_floor_70(freq_floor_70), .o_backchan_en(backchan_en),
      .o_backchan_last_addr(backchan_last_addr));
   ////////////////////////////////////////////////////////////////////////////
   task results;
      if (fail_count == 0 && compares > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : results
   task chk_word(input logic [15:0] got, input logic [15:0] exp);
      compares++;
      if (got !== exp) begin
         fail_count++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk_word
   task chk_bit(input logic got, input logic exp);
      chk_word({15'h0000, got}, {15'h0000, exp});
   endtask : chk_bit
   task step(input int n);
      repeat (n) @(posedge clk_sys);
      #2;
   endtask : step
   // Answers stand one cycle, so they are captured right after the taking edge
   task op(input logic wr, input logic [7:0] code, input logic [15:0] wd);
      cmd = '{wr: wr, rd: !wr, code: code, wdata: wd};
      step(1);
      {rdat_s, rv_s, ic_s, id_s} = {rd_data, rd_valid, invalid_cmd, invalid_data};
      cmd = '0;
      step(1);
   endtask : op
   task boot(input logic [3:0] stk);
      srst = 1'b1;
      nvm_stack_stop = stk;
      step(5);
      srst = 1'b0;
      step(2);
   endtask : boot
   always @(posedge clk_sys) begin
      cycles++;
      if (cycles == 5000) begin
         fail_count++;
         results();
      end
   end
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      boot(4'h0);
      chk_bit(power_good_out, 1'b0);
      op(1'b0, 8'he3, 16'h0000);
      chk_word(rdat_s, 16'h10ff);
      op(1'b0, 8'he4, 16'h0000);
      chk_word(rdat_s, 16'h0090);
      // All sync writes but 00b1 keep the low five bits at 10000b
      for (int k = 0; k < 13; k++) begin
         op(1'b1, rows[k].code, rows[k].wd);
         chk_bit(ic_s, rows[k].ic);
         chk_bit(id_s, rows[k].id);
         op(1'b0, rows[k].code, 16'h0000);
         chk_bit(rv_s, !rows[k].ic);
         if (!rows[k].ic) chk_word(rdat_s, rows[k].rd);
      end
      chk_bit(sync_rising_sel, 1'b1);
      chk_bit(backchan_en, 1'b0);
      chk_word({12'h000, backchan_last_addr}, 16'h0000);
      // Fall delay code 2 is five ticks, rise code 0 one tick, top source masked
      op(1'b1, 8'he3, 16'h2080);
      phase.enabled = 1'b1;
      step(6);
      chk_bit(power_good_out, 1'b1);
      events = 8'h80;
      step(12);
      chk_bit(power_good_out, 1'b1);
      {events, keep_running} = 16'h4040;
      step(12);
      chk_bit(power_good_out, 1'b1);
      {events, keep_running} = 16'h0000;
      step(3);
      events = 8'h20;
      step(3);
      events = 8'h00;
      step(1);
      events = 8'h20;
      step(3);
      events = 8'h00;
      step(4);
      chk_bit(power_good_out, 1'b1);
      events = 8'h20;
      step(3);
      chk_bit(power_good_out, 1'b1);
      step(5);
      chk_bit(power_good_out, 1'b0);
      events = 8'h00;
      step(3);
      chk_bit(power_good_out, 1'b1);
      phase.toff_fall = 1'b1;
      step(2);
      chk_bit(power_good_out, 1'b0);
      phase.toff_fall = 1'b0;
      step(4);
      phase.ton_rise = 1'b1;
      step(2);
      chk_bit(power_good_out, 1'b0);
      phase.ton_rise = 1'b0;
      op(1'b1, 8'he3, 16'h0000);
      chk_bit(ic_s, 1'b1);
      op(1'b0, 8'he3, 16'h0000);
      chk_word(rdat_s, 16'h2080);
      op(1'b1, 8'hec, 16'h0001);
      chk_bit(ic_s, 1'b1);
      phase.enabled = 1'b0;
      // Auto-detect with a live sync source, then the in-to-out change
      op(1'b1, 8'he4, 16'h00f0);
      run = 1'b1;
      step(20);
      phase.enabled = 1'b1;
      step(4);
      chk_bit(sync_in_en, 1'b1);
      locks = 0;
      repeat (80) begin
         step(1);
         if (osc_lock === 1'b1) locks++;
      end
      chk_bit(locks >= 8, 1'b1);
      at_in_low_limit = 1'b1;
      op(1'b1, 8'he4, 16'h0050);
      step(3);
      chk_bit(freq_floor_70, 1'b1);
      {phase.enabled, at_in_low_limit} = 2'b00;
      step(2);
      phase.enabled = 1'b1;
      step(3);
      chk_bit(freq_floor_70, 1'b0);
      {phase.enabled, run} = 2'b00;
      op(1'b1, 8'he4, 16'h00f0);
      step(20);
      phase.enabled = 1'b1;
      step(4);
      chk_bit(sync_out_en, 1'b1);
      {phase.enabled, follower, run} = 3'b011;
      step(20);
      phase.enabled = 1'b1;
      step(30);
      chk_bit(sync_fault, 1'b0);
      chk_bit(sync_in_en, 1'b1);
      run = 1'b0;
      step(40);
      chk_bit(sync_fault, 1'b1);
      follower = 1'b0;
      op(1'b1, 8'he4, 16'h0050);
      chk_bit(freq_floor_70, 1'b1);
      {phase.enabled, sync_fault_clr} = 2'b01;
      step(1);
      sync_fault_clr = 1'b0;
      step(2);
      chk_bit(sync_fault, 1'b0);
      follower = 1'b0;
      boot(4'h2);
      chk_bit(backchan_en, 1'b1);
      chk_word({12'h000, backchan_last_addr}, 16'h0002);
      op(1'b1, 8'hec, 16'h0001);
      step(3);
      chk_word({12'h000, backchan_last_addr}, 16'h0001);
      results();
   end
endmodule : tb_pgsync_config_bank
